/* src/fdp_top.sv */
`timescale 1ns/1ns
`default_nettype none
module fdp_top (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire fdp_pkg::fdp_sfr_req_t i_sfr,
    output logic [7:0] o_sfr_rdata,
    input wire logic i_core_idle,
    input wire logic i_core_stop,
    input wire fdp_pkg::fdp_fetch_t i_fetch,
    input wire logic [7:0] i_flash_rdata,
    output logic [7:0] o_fetch_data,
    input wire logic i_opcode_exec,
    input wire logic [7:0] i_opcode,
    input wire logic i_reti,
    input wire logic i_instr_done,
    input wire logic i_irq_flag_clr,
    input wire logic i_irq_enable,
    output logic o_irq_flag,
    output logic o_irq_take,
    output logic [15:0] o_irq_vector,
    output logic o_core_stall,
    input wire logic i_page_locked,
    output logic [7:0] o_lock_page,
    output logic [14:0] o_flash_addr,
    output logic [7:0] o_flash_wdata,
    output logic o_flash_erase,
    output logic o_flash_prog,
    output logic o_flash_standby,
    output logic [10:0] o_ram_addr,
    output logic o_ram_rd,
    input wire logic [7:0] i_ram_rdata
);
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_ERASE = 5'b00010,
        ST_FETCH = 5'b00100,
        ST_PROG  = 5'b01000,
        ST_DONE  = 5'b10000
    } fdp_state_t;

    fdp_state_t state_r;
    logic [7:0] page_sel_r;
    logic [1:0] pwr_sel_r;
    logic arm_r;
    logic [3:0] base_r;
    logic [7:0] timing_r;
    logic [7:0] scratch_r;
    logic [7:0] patch_data_r;
    logic [15:0] patch_addr_r;
    logic [7:0] rdata_r;
    logic [6:0] ofs_r;
    logic [7:0] wdata_r;
    logic idle_q_r;
    logic flag_r;
    logic inhibit_r;
    logic [3:0] brk_cnt_r;
    logic idle_entry;
    logic start_write;
    logic lock_fail;
    logic brk;
    logic tmr_start;
    logic tmr_busy;
    logic tmr_done;
    logic [7:0] ctrl_rd;
    logic [7:0] tmr_scale;

    ////////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            page_sel_r <= fdp_pkg::RST_PAGE_SEL;
            pwr_sel_r <= fdp_pkg::PWR_ALWAYS_ON;
            base_r <= 4'h0;
            timing_r <= fdp_pkg::RST_TIMING;
            scratch_r <= fdp_pkg::RST_BYTE;
            patch_data_r <= fdp_pkg::RST_BYTE;
            patch_addr_r <= fdp_pkg::PATCH_OFF;
        end else if (i_sfr.wr) begin
            unique case (i_sfr.addr)
                fdp_pkg::ADDR_PAGE_SEL: page_sel_r <= i_sfr.wdata;
                fdp_pkg::ADDR_WR_CTRL: begin
                    pwr_sel_r <= i_sfr.wdata[fdp_pkg::CTRL_PWR_HI:
                                             fdp_pkg::CTRL_PWR_LO];
                    base_r <= i_sfr.wdata[fdp_pkg::CTRL_BASE_HI:
                                          fdp_pkg::CTRL_BASE_LO];
                end
                fdp_pkg::ADDR_WR_TIMING: timing_r <= i_sfr.wdata;
                // scratch drives nothing inside the block
                fdp_pkg::ADDR_SCRATCH: scratch_r <= i_sfr.wdata;
                fdp_pkg::ADDR_PATCH_DATA: patch_data_r <= i_sfr.wdata;
                fdp_pkg::ADDR_PATCH_LOW: patch_addr_r[7:0] <= i_sfr.wdata;
                fdp_pkg::ADDR_PATCH_HIGH: patch_addr_r[15:8] <= i_sfr.wdata;
                default: ;
            endcase
        end
    end

    // arm is dropped by hardware at every idle entry, launched or refused, so the next
    // idle entry does not repeat it; a software write in that cycle loses
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            arm_r <= 1'b0;
        end else if (idle_entry) begin
            arm_r <= 1'b0;
        end else if (i_sfr.wr && i_sfr.addr == fdp_pkg::ADDR_WR_CTRL) begin
            arm_r <= i_sfr.wdata[fdp_pkg::CTRL_ARM_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path, one cycle latency; protection bits have no address
    assign ctrl_rd = {1'b0, pwr_sel_r, arm_r, base_r};

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            rdata_r <= fdp_pkg::RST_BYTE;
        end else if (i_sfr.rd) begin
            unique case (i_sfr.addr)
                fdp_pkg::ADDR_PAGE_SEL: rdata_r <= page_sel_r;
                fdp_pkg::ADDR_WR_CTRL: rdata_r <= ctrl_rd;
                fdp_pkg::ADDR_WR_TIMING: rdata_r <= timing_r;
                fdp_pkg::ADDR_SCRATCH: rdata_r <= scratch_r;
                fdp_pkg::ADDR_PATCH_DATA: rdata_r <= patch_data_r;
                fdp_pkg::ADDR_PATCH_LOW: rdata_r <= patch_addr_r[7:0];
                fdp_pkg::ADDR_PATCH_HIGH: rdata_r <= patch_addr_r[15:8];
                default: rdata_r <= fdp_pkg::RST_BYTE;
            endcase
        end
    end

    assign o_sfr_rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // page write sequencer
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            idle_q_r <= 1'b0;
        end else begin
            idle_q_r <= i_core_idle;
        end
    end

    assign idle_entry = i_core_idle && !idle_q_r;
    assign start_write = idle_entry && arm_r && !i_page_locked;
    assign lock_fail = idle_entry && arm_r && i_page_locked;
    assign tmr_start = start_write ||
                       (state_r == ST_FETCH);
    assign tmr_scale = (state_r == ST_IDLE) ? fdp_pkg::ERASE_SCALE
                                            : fdp_pkg::PROG_SCALE;

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            state_r <= ST_IDLE;
            ofs_r <= 7'h00;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    ofs_r <= 7'h00;
                    if (start_write) begin
                        state_r <= ST_ERASE;
                    end
                end
                ST_ERASE: begin
                    if (tmr_done) begin
                        state_r <= ST_FETCH;
                    end
                end
                ST_FETCH: state_r <= ST_PROG;
                ST_PROG: begin
                    if (tmr_done) begin
                        ofs_r <= ofs_r + 7'h01;
                        state_r <= (ofs_r == fdp_pkg::OFS_LAST) ? ST_DONE
                                                                : ST_FETCH;
                    end
                end
                ST_DONE: state_r <= ST_IDLE;
            endcase
        end
    end

    // RAM data is taken in the same cycle as the read strobe in fetch state
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            wdata_r <= fdp_pkg::RST_BYTE;
        end else if (state_r == ST_FETCH) begin
            wdata_r <= i_ram_rdata;
        end
    end

    fdp_pulse_timer u_timer (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_start(tmr_start),
        .i_timing(timing_r),
        .i_scale(tmr_scale),
        .o_busy(tmr_busy),
        .o_done(tmr_done)
    );

    assign o_flash_addr = {page_sel_r, ofs_r};
    assign o_lock_page = page_sel_r;
    assign o_flash_wdata = wdata_r;
    assign o_flash_erase = (state_r == ST_ERASE) && tmr_busy;
    assign o_flash_prog = (state_r == ST_PROG) && tmr_busy;
    assign o_ram_addr = {base_r, ofs_r};
    assign o_ram_rd = (state_r == ST_FETCH);

    ////////////////////////////////////////////////////////////////////////
    // flash/debug interrupt flag; a set beats a clear in the same cycle
    assign brk = i_opcode_exec && (i_opcode == fdp_pkg::BREAK_OPCODE);

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            flag_r <= 1'b0;
        end else if (brk || lock_fail || state_r == ST_DONE) begin
            flag_r <= 1'b1;
        end else if (i_irq_flag_clr) begin
            flag_r <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            brk_cnt_r <= 4'h0;
        end else if (brk) begin
            brk_cnt_r <= fdp_pkg::BREAK_STALL_CYC;
        end else if (brk_cnt_r != 4'h0) begin
            brk_cnt_r <= brk_cnt_r - 4'h1;
        end
    end

    // after a return the core must retire one instruction first
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            inhibit_r <= 1'b0;
        end else if (i_reti) begin
            inhibit_r <= 1'b1;
        end else if (i_instr_done) begin
            inhibit_r <= 1'b0;
        end
    end

    assign o_irq_flag = flag_r;
    assign o_irq_take = flag_r && i_irq_enable && !inhibit_r;
    assign o_irq_vector = fdp_pkg::FDBG_VECTOR;
    assign o_core_stall = (state_r != ST_IDLE) ||
                          (brk_cnt_r != 4'h0);

    // standby never while the sequencer owns the array
    always_comb begin
        o_flash_standby = 1'b0;
        if (state_r == ST_IDLE) begin
            unique case (pwr_sel_r)
                fdp_pkg::PWR_STBY_IDLE:
                    o_flash_standby = i_core_idle || i_core_stop;
                fdp_pkg::PWR_STBY_FETCH:
                    o_flash_standby = i_core_idle || i_core_stop ||
                                      !i_fetch.valid;
                default: o_flash_standby = 1'b0;
            endcase
        end
    end

    fdp_patch u_patch (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_fetch(i_fetch),
        .i_flash_rdata(i_flash_rdata),
        .i_patch_address(patch_addr_r),
        .i_patch_data(patch_data_r),
        .o_fetch_data(o_fetch_data)
    );

    ////////////////////////////////////////////////////////////////////////
    sequence s_armed_entry;
        idle_entry && arm_r;
    endsequence

    a_no_arm_write: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn)
        idle_entry && !arm_r && state_r == ST_IDLE |=> state_r == ST_IDLE)
        else $error("write started without arm");
    a_lock_irq: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn)
        s_armed_entry ##0 i_page_locked |=> flag_r && state_r == ST_IDLE)
        else $error("locked page not refused with interrupt");
    a_erase_first: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn)
        s_armed_entry ##0 !i_page_locked |=> o_flash_erase ##0 o_core_stall)
        else $error("armed idle entry did not start erase");
    a_done_irq: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn)
        state_r == ST_DONE |=> flag_r && !o_core_stall)
        else $error("completion without interrupt");
    a_break_stall: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn)
        brk && state_r == ST_IDLE |=> (flag_r && o_core_stall) [*4])
        else $error("break did not flag and stall");
    a_step_gate: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn)
        i_reti ##1 !i_instr_done |-> !o_irq_take)
        else $error("interrupt retaken before one instruction");
    a_ctrl_bit7: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn)
        $past(i_sfr.rd) && $past(i_sfr.addr) == fdp_pkg::ADDR_WR_CTRL
        |-> !o_sfr_rdata[fdp_pkg::CTRL_RSVD_BIT])
        else $error("reserved control bit read non-zero");
    a_flash_addr: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn)
        o_flash_prog |-> o_flash_addr[14:7] == page_sel_r)
        else $error("programming outside selected page");
endmodule : fdp_top
`default_nettype wire

/* src/fdp_pkg.sv */
package fdp_pkg;

    // special function register addresses
    localparam logic [7:0] ADDR_PAGE_SEL = 8'h00_AE;
    localparam logic [7:0] ADDR_WR_CTRL = 8'h00_AF;
    localparam logic [7:0] ADDR_WR_TIMING = 8'h00_DD;
    localparam logic [7:0] ADDR_SCRATCH = 8'h00_E7;
    localparam logic [7:0] ADDR_PATCH_DATA = 8'h00_B9;
    localparam logic [7:0] ADDR_PATCH_LOW = 8'h00_BA;
    localparam logic [7:0] ADDR_PATCH_HIGH = 8'h00_BB;

    // reset values
    localparam logic [7:0] RST_PAGE_SEL = 8'h00_00;
    localparam logic [7:0] RST_TIMING = 8'h00_0A;
    localparam logic [7:0] RST_BYTE = 8'h00_00;

    // control register fields
    localparam int CTRL_RSVD_BIT = 7;
    localparam int CTRL_PWR_HI = 6;
    localparam int CTRL_PWR_LO = 5;
    localparam int CTRL_ARM_BIT = 4;
    localparam int CTRL_BASE_HI = 3;
    localparam int CTRL_BASE_LO = 0;

    localparam logic [1:0] PWR_ALWAYS_ON = 2'h0;
    localparam logic [1:0] PWR_STBY_IDLE = 2'h1;
    localparam logic [1:0] PWR_STBY_FETCH = 2'h2;

    localparam logic [7:0] BREAK_OPCODE = 8'h00_A5;
    localparam logic [15:0] FDBG_VECTOR = 16'h0033;
    localparam logic [15:0] PATCH_OFF = 16'h0000;

    localparam int PAGE_BYTES = 128;
    localparam int OFS_W = $clog2(PAGE_BYTES);
    localparam logic [OFS_W-1:0] OFS_LAST = OFS_W'(PAGE_BYTES - 1);

    // write pulse length is the timing value times these scales
    localparam logic [7:0] ERASE_SCALE = 8'h00_40;
    localparam logic [7:0] PROG_SCALE = 8'h00_01;

    // stall after a break opcode, 160 ns at 40 ns per cycle
    localparam int CLK_NS = 40;
    localparam int BREAK_STALL_NS = 160;
    localparam logic [3:0] BREAK_STALL_CYC =
        4'((BREAK_STALL_NS + CLK_NS - 1) / CLK_NS);

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fdp_sfr_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
    } fdp_fetch_t;

endpackage : fdp_pkg

/* src/fdp_pulse_timer.sv */
`timescale 1ns/1ns
`default_nettype none
// counts timing value times scale cycles, then pulses o_done
module fdp_pulse_timer (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_start,
    input wire logic [7:0] i_timing,
    input wire logic [7:0] i_scale,
    output logic o_busy,
    output logic o_done
);
    logic [15:0] count_r;
    logic busy_r;
    logic [15:0] load;
    logic [15:0] product;

    // zero timing still gives one cycle, never a stuck counter
    assign product = 16'(i_timing) * 16'(i_scale);
    assign load = (product == 16'h0000) ? 16'h0001 : product;

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            count_r <= 16'h0000;
            busy_r <= 1'b0;
        end else if (i_start) begin
            count_r <= load;
            busy_r <= 1'b1;
        end else if (busy_r) begin
            count_r <= count_r - 16'h0001;
            busy_r <= (count_r != 16'h0001);
        end
    end

    assign o_busy = busy_r;
    assign o_done = busy_r && (count_r == 16'h0001);

    a_timer_len: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        i_start && load == 16'h0001 |=> o_done)
        else $error("timer one-cycle load did not finish");
endmodule : fdp_pulse_timer
`default_nettype wire

/* src/fdp_patch.sv */
`timescale 1ns/1ns
`default_nettype none
// program fetch byte replacement, any byte but address zero, opcode or operand
module fdp_patch (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire fdp_pkg::fdp_fetch_t i_fetch,
    input wire logic [7:0] i_flash_rdata,
    input wire logic [15:0] i_patch_address,
    input wire logic [7:0] i_patch_data,
    output logic [7:0] o_fetch_data
);
    logic hit;
    logic [7:0] data_r;

    assign hit = (i_patch_address != fdp_pkg::PATCH_OFF) &&
                 (i_fetch.addr == i_patch_address);

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            data_r <= fdp_pkg::RST_BYTE;
        end else if (i_fetch.valid) begin
            data_r <= hit ? i_patch_data : i_flash_rdata;
        end
    end

    assign o_fetch_data = data_r;

    a_patch_hit: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn)
        i_fetch.valid && hit |=> o_fetch_data == $past(i_patch_data))
        else $error("patch data not returned on address match");
    a_patch_off: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn)
        i_fetch.valid && i_patch_address == fdp_pkg::PATCH_OFF
        |=> o_fetch_data == $past(i_flash_rdata))
        else $error("replacement active with zero address");
endmodule : fdp_patch
`default_nettype wire

/* bench/fdp_far_model.sv */
`timescale 1ns/1ns
`default_nettype none
// program flash, external ram and lock decode as seen from the block
module fdp_far_model #(
    parameter logic [7:0] LOCK_PAGE = 8'h00_07
) (
    input wire logic i_sys_clk,
    input wire fdp_pkg::fdp_fetch_t i_fetch,
    input wire logic [10:0] i_ram_addr,
    input wire logic i_ram_rd,
    input wire logic [7:0] i_lock_page,
    output logic [7:0] o_flash_rdata,
    output logic [7:0] o_ram_rdata,
    output logic o_page_locked
);
    logic [7:0] cyc_r = 8'h00_00;
    always_ff @(posedge i_sys_clk) begin
        cyc_r <= cyc_r + 8'h00_01;
    end
    // an unselected bus shows a moving pattern, never the last byte
    assign o_flash_rdata = i_fetch.valid ?
        (i_fetch.addr[7:0] ^ i_fetch.addr[15:8] ^ 8'h00_3C) : cyc_r;
    // buffer sits at a multiple of 128 whatever the base bits
    assign o_ram_rdata = i_ram_rd ?
        (i_ram_addr[7:0] ^ 8'(i_ram_addr[10:8]) ^ 8'h00_5A) : ~cyc_r;
    // protection lives outside the core's reach
    assign o_page_locked = (i_lock_page == LOCK_PAGE);
endmodule : fdp_far_model
`default_nettype wire

/* bench/fdp_top_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module fdp_top_tb;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    fdp_pkg::fdp_sfr_req_t sfr = '0;
    fdp_pkg::fdp_fetch_t fetch = '0;
    logic idle = 1'b0, stop = 1'b0, op_exec = 1'b0, reti = 1'b0;
    logic idone = 1'b0, fclr = 1'b0, ien = 1'b0;
    logic [7:0] opcode = 8'h00_00;
    logic [7:0] rdata, fdata, lock_page, fwdata, flash_rdata, ram_rdata;
    logic [14:0] faddr;
    logic [10:0] ram_addr;
    logic [15:0] vec, pa;
    logic flag, take, stall, locked, erase, prog, stby, ram_rd;
    logic rd_d = 1'b0, fv_d = 1'b0, prog_d = 1'b0;
    logic [23:0] exp_q[$];
    logic [10:0] ra;
    logic [7:0] pd;
    logic [3:0] base;
    int fail_count = 0, samples_checked = 0, erase_cnt = 0, seed;

    always #20 sys_clk = ~sys_clk;

    fdp_top fdp_top_i (
        .i_sys_clk(sys_clk), .i_resetn(resetn), .i_sfr(sfr),
        .o_sfr_rdata(rdata), .i_core_idle(idle), .i_core_stop(stop),
        .i_fetch(fetch), .i_flash_rdata(flash_rdata), .o_fetch_data(fdata),
        .i_opcode_exec(op_exec), .i_opcode(opcode), .i_reti(reti),
        .i_instr_done(idone), .i_irq_flag_clr(fclr), .i_irq_enable(ien),
        .o_irq_flag(flag), .o_irq_take(take), .o_irq_vector(vec),
        .o_core_stall(stall), .i_page_locked(locked),
        .o_lock_page(lock_page), .o_flash_addr(faddr),
        .o_flash_wdata(fwdata), .o_flash_erase(erase), .o_flash_prog(prog),
        .o_flash_standby(stby), .o_ram_addr(ram_addr), .o_ram_rd(ram_rd),
        .i_ram_rdata(ram_rdata)
    );
    fdp_far_model fdp_far_model_i (
        .i_sys_clk(sys_clk), .i_fetch(fetch), .i_ram_addr(ram_addr),
        .i_ram_rd(ram_rd), .i_lock_page(lock_page),
        .o_flash_rdata(flash_rdata), .o_ram_rdata(ram_rdata),
        .o_page_locked(locked)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic complete_run();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run
    function automatic logic [7:0] fl(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h00_3C;
    endfunction : fl
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        sfr <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        sfr <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00_00};
        exp_q.push_back({16'h0000, e});
        @(posedge sys_clk);
        sfr <= '0;
    endtask : rd
    task automatic fch(input logic [15:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        fetch <= '{valid: 1'b1, addr: a};
        exp_q.push_back({16'h0000, e});
        @(posedge sys_clk);
        fetch <= '0;
    endtask : fch
    task automatic pulse(input logic [3:0] w);
        @(posedge sys_clk);
        {op_exec, reti, idone, fclr} <= w;
        @(posedge sys_clk);
        {op_exec, reti, idone, fclr} <= 4'h0;
    endtask : pulse
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : settle

    ////////////////////////////////////////////////////////////////////////
    // results appear a cycle after the request, oldest note first
    always @(posedge sys_clk) begin
        if (rd_d || fv_d) begin
            chk({16'h0000, rd_d ? rdata : fdata},
                exp_q.size() > 0 ? exp_q.pop_front() : 24'hFF_FFFF);
        end
        if (prog && !prog_d) begin
            chk({1'b0, faddr, fwdata},
                exp_q.size() > 0 ? exp_q.pop_front() : 24'hFF_FFFF);
        end
        if (erase) erase_cnt++;
        rd_d <= sfr.rd;
        fv_d <= fetch.valid;
        prog_d <= prog;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        complete_run();
    end

    initial begin
        seed = $urandom(11403);
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(fdp_pkg::ADDR_PAGE_SEL, 8'h00_00);
        rd(fdp_pkg::ADDR_WR_CTRL, 8'h00_00);
        rd(fdp_pkg::ADDR_WR_TIMING, 8'h00_0A);
        rd(fdp_pkg::ADDR_SCRATCH, 8'h00_00);
        pd = 8'($urandom);
        wr(fdp_pkg::ADDR_SCRATCH, pd);
        rd(fdp_pkg::ADDR_SCRATCH, pd);
        rd(8'h00_C0, 8'h00_00);
        wr(fdp_pkg::ADDR_WR_CTRL, 8'h00_8F);
        rd(fdp_pkg::ADDR_WR_CTRL, 8'h00_0F);
        wr(fdp_pkg::ADDR_WR_TIMING, 8'h00_01);
        rd(fdp_pkg::ADDR_WR_TIMING, 8'h00_01);
        // standby over every mode, idle, stop and fetch activity
        for (int p = 0; p < 3; p++) begin
            for (int k = 0; k < 8; k++) begin
                wr(fdp_pkg::ADDR_WR_CTRL, 8'(p << 5));
                @(posedge sys_clk);
                idle <= k[0];
                stop <= k[2];
                fetch <= '{valid: k[1], addr: 16'h0000};
                if (k[1]) exp_q.push_back(24'h00_003C);
                #1;
                chk(24'(stby), 24'((p == 1 && (k[0] || k[2])) || (p == 2 &&
                    (k[0] || k[2] || !k[1]))));
                @(posedge sys_clk);
                idle <= 1'b0;
                stop <= 1'b0;
                fetch <= '0;
            end
        end
        // fetch replacement; high byte moved first
        pa = 16'($urandom) | 16'h0100;
        fch(pa, fl(pa));
        wr(fdp_pkg::ADDR_PATCH_DATA, pd);
        wr(fdp_pkg::ADDR_PATCH_HIGH, pa[15:8]);
        wr(fdp_pkg::ADDR_PATCH_LOW, pa[7:0]);
        fch(pa, pd);
        fch(pa + 16'h0001, fl(pa + 16'h0001));
        wr(fdp_pkg::ADDR_PATCH_HIGH, 8'h00_00);
        wr(fdp_pkg::ADDR_PATCH_LOW, 8'h00_00);
        fch(16'h0000, fl(16'h0000));
        // break opcode, then single step on return
        ien <= 1'b1;
        // even opcodes only, so the random byte can never be the break code
        opcode <= 8'($urandom) & 8'h00_FE;
        pulse(4'h8);
        #1;
        chk(24'(flag), 24'h00_0000);
        opcode <= fdp_pkg::BREAK_OPCODE;
        pulse(4'h8);
        #1;
        chk({flag, stall, take, vec}, {5'h00, 3'b111, 16'h0033});
        settle(6);
        chk(24'(stall), 24'h00_0000);
        pulse(4'h4);
        settle(2);
        chk(24'(take), 24'h00_0000);
        pulse(4'h2);
        #1;
        chk(24'(take), 24'h00_0001);
        pulse(4'h1);
        #1;
        chk(24'(flag), 24'h00_0000);
        // armed page write with timing value 1
        base = 4'($urandom);
        wr(fdp_pkg::ADDR_PAGE_SEL, 8'h00_05);
        wr(fdp_pkg::ADDR_WR_CTRL, {4'h1, base});
        for (int i = 0; i < 128; i++) begin
            ra = {base, 7'(i)};
            exp_q.push_back({1'b0, 8'h00_05, 7'(i),
                ra[7:0] ^ 8'(ra[10:8]) ^ 8'h00_5A});
        end
        erase_cnt = 0;
        @(posedge sys_clk);
        idle <= 1'b1;
        settle(3);
        chk(24'(stall), 24'h00_0001);
        for (int n = 0; n < 1000 && flag !== 1'b1; n++) settle(1);
        chk({22'(erase_cnt), stall, flag}, {22'd64, 2'b01});
        chk(24'(exp_q.size()), 24'h00_0000);
        @(posedge sys_clk);
        idle <= 1'b0;
        rd(fdp_pkg::ADDR_WR_CTRL, {4'h0, base});
        pulse(4'h1);
        // arm withdrawn before idle
        wr(fdp_pkg::ADDR_WR_CTRL, 8'h00_10);
        wr(fdp_pkg::ADDR_WR_CTRL, 8'h00_00);
        erase_cnt = 0;
        @(posedge sys_clk);
        idle <= 1'b1;
        settle(80);
        chk({22'(erase_cnt), stall, flag}, 24'h00_0000);
        @(posedge sys_clk);
        idle <= 1'b0;
        // locked page
        wr(fdp_pkg::ADDR_PAGE_SEL, 8'h00_07);
        wr(fdp_pkg::ADDR_WR_CTRL, 8'h00_10);
        @(posedge sys_clk);
        idle <= 1'b1;
        settle(2);
        chk(24'(flag), 24'h00_0001);
        settle(70);
        chk(24'(erase_cnt), 24'h00_0000);
        complete_run();
    end
endmodule : fdp_top_tb
`default_nettype wire
